// >>> logic/signaling_extractor_pkg.sv
// constants shared by the signaling extractor register slice
`default_nettype none
package signaling_extractor_pkg;
   // direct register offsets
   localparam logic [7:0] CFG_OFS = 8'h50;
   localparam logic [7:0] STAT_OFS = 8'h51;
   localparam logic [7:0] ADDR_OFS = 8'h52;
   localparam logic [7:0] DATA_OFS = 8'h53;
   // direct register fields
   localparam int VIEW_BIT = 6;
   localparam int PER_SLOT_CONFIG_ENABLE_BIT = 0;
   localparam int BUSY_BIT = 7;
   localparam int RNW_BIT = 7;
   localparam logic [7:0] CFG_RST = 8'h00;
   localparam logic [7:0] ADDR_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   // indirect space segment bases
   localparam logic [6:0] CUR_BASE = 7'h10;
   localparam logic [6:0] DLY_BASE = 7'h20;
   localparam logic [6:0] DLY_T1_TOP = 7'h37;
   localparam logic [6:0] PCFG_BASE = 7'h40;
   localparam logic [6:0] PCFG_TOP = 7'h5f;
   // per-slot configuration fields
   localparam int PC_INV_HI = 3;
   localparam int PC_INV_LO = 2;
   localparam int PC_FIX_LVL = 1;
   localparam int PC_DEB = 0;
   localparam logic [3:0] PCFG_RST = 4'h0;
   // slot numbering
   localparam logic [4:0] E1_SKIP_TS = 5'h10;
   localparam logic [4:0] E1_FLAG16_TS = 5'h11;
   localparam logic [4:0] LAST_DIRECT_FLAG = 5'h0f;
   localparam logic [4:0] T1_LAST_FLAG = 5'h10;
   // pcm conditioning masks, bit 1 of the slot is the msb
   localparam logic [7:0] E1_EVEN_MASK = 8'h55;
   localparam logic [7:0] E1_ODD_MASK = 8'haa;
   localparam logic [7:0] MSB_MASK = 8'h80;
   // cycles the busy flag stays high per indirect access
   localparam int INDIRECT_CYCLES = 2;
endpackage
`default_nettype wire

// >>> logic/signaling_extract_indirect_regs.sv
// signaling extractor change flags, indirect space and rx pcm conditioning
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sig_fifo #(
   parameter int WIDTH = 10,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,               // core clock
   input wire logic rst_i,               // async reset
   input wire logic in_valid_i,          // word offered
   output logic in_ready_o,              // room for a word
   input wire logic [WIDTH-1:0] in_data_i, // word in
   output logic out_valid_o,             // word held
   input wire logic out_ready_i,         // drain takes word
   output logic [WIDTH-1:0] out_data_o   // word out
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic room;
   logic push;
   logic pop;
   logic [AW:0] next_count;

   assign push = in_valid_i && room;
   assign pop = out_valid_o && out_ready_i;
   assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);
   // ready leaves straight from a flop
   assign in_ready_o = room;
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rd_ptr];

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
         room <= 1'b1;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= next_count;
         room <= (next_count != (AW+1)'(DEPTH));
      end
   end

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end
endmodule // sig_fifo

////////////////////////////////////////////////////////////////////////////////
module signaling_extract_indirect_regs #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic core_clk_i,          // 20 MHz system clock
   input wire logic rst_i,               // async reset, active high
   input wire logic [7:0] reg_addr_i,    // register offset
   input wire logic reg_wr_i,            // write strobe, one cycle
   input wire logic reg_rd_i,            // read strobe, one cycle
   input wire logic [7:0] reg_wdata_i,   // write data
   output logic [7:0] reg_rdata_o,       // read data, next cycle
   input wire logic e1_not_t1_select_i,  // 1 = E1, 0 = T1
   input wire logic sig_valid_i,         // signaling sample offered
   output logic sig_ready_o,             // sample buffer has room
   input wire logic [4:0] sig_slot_i,    // E1 timeslot or T1 channel
   input wire logic [3:0] sig_nibble_i,  // ABCD sample
   input wire logic sig_mf_start_i,      // first sample of a multiframe
   input wire logic pcm_valid_i,         // pcm byte offered
   input wire logic [4:0] pcm_slot_i,    // slot of pcm byte
   input wire logic [7:0] pcm_data_i,    // received pcm byte
   input wire logic pcm_sig_frame_i,     // byte is in a signaling frame
   input wire logic msb_invert_control_i, // per-channel sign invert
   input wire logic trunk_cond_i,        // trunk conditioning active
   input wire logic [7:0] trunk_code_i,  // trunk conditioning code
   input wire logic milliwatt_i,         // milliwatt insertion active
   input wire logic [7:0] milliwatt_code_i, // milliwatt byte
   output logic pcm_valid_o,             // conditioned byte valid
   output logic [7:0] backplane_rx_pcm_out_o // conditioned pcm byte
);
   typedef enum {IX_IDLE, IX_BUSY} ix_state_e;

   function automatic logic [4:0] slot_index(input logic [4:0] s, input logic e1);
      // T1 channels count from one, storage from zero
      slot_index = e1 ? s : s - 5'h01;
   endfunction

   function automatic logic [15:0] flag_bit(input logic [4:0] s, input logic e1);
      flag_bit = '0;
      if (e1) begin
         if (s != 5'h00 && s <= signaling_extractor_pkg::LAST_DIRECT_FLAG) begin
            flag_bit[4'(s - 5'h01)] = 1'b1;
         end else if (s == signaling_extractor_pkg::E1_FLAG16_TS) begin
            flag_bit[15] = 1'b1;
         end
      end else if (s != 5'h00 && s <= signaling_extractor_pkg::T1_LAST_FLAG) begin
         flag_bit[4'(s - 5'h01)] = 1'b1;
      end
   endfunction

   function automatic logic slot_valid(input logic [4:0] s, input logic e1);
      slot_valid = e1 ? (s != 5'h00 && s != signaling_extractor_pkg::E1_SKIP_TS) : (s != 5'h00 && s <= 5'h18);
   endfunction

   logic [7:0] cfg;
   logic [7:0] addr_ctrl;
   logic [7:0] data_buf;
   logic [15:0] flags;
   logic [3:0] cur_sig [32];
   logic [3:0] dly_sig [32];
   logic [3:0] prev_smp [32];
   logic [3:0] pcfg [32];
   ix_state_e state;
   logic [1:0] ix_cnt;
   logic view;
   logic per_slot_config_enable;
   logic e1;
   logic launch;
   logic ix_done;
   logic [7:0] ind_rdata;
   logic [9:0] fifo_word;
   logic pop_valid;
   logic pop_ready;
   logic pop;
   logic [4:0] pop_slot;
   logic [4:0] pop_idx;
   logic [3:0] pop_nib;
   logic pop_mf;
   logic [3:0] accepted;
   logic change;
   logic [15:0] flag_set;
   logic [15:0] flag_clr;

   assign view = cfg[signaling_extractor_pkg::VIEW_BIT];
   assign per_slot_config_enable = cfg[signaling_extractor_pkg::PER_SLOT_CONFIG_ENABLE_BIT];
   assign e1 = e1_not_t1_select_i;

   ////////////////////////////////////////////////////////////////////////////
   // sample buffer; drained only while no indirect access touches the arrays
   sig_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .in_valid_i(sig_valid_i),
      .in_ready_o(sig_ready_o),
      .in_data_i({sig_mf_start_i, sig_slot_i, sig_nibble_i}),
      .out_valid_o(pop_valid),
      .out_ready_i(pop_ready),
      .out_data_o(fifo_word)
   );
   assign pop_ready = (state == IX_IDLE);
   assign pop = pop_valid && pop_ready;
   assign {pop_mf, pop_slot, pop_nib} = fifo_word;
   assign pop_idx = slot_index(pop_slot, e1);

   ////////////////////////////////////////////////////////////////////////////
   // debounce and change detection
   always_comb begin
      accepted = pop_nib;
      if (per_slot_config_enable && pcfg[pop_idx][signaling_extractor_pkg::PC_DEB]) begin
         accepted = (pop_nib & ~(pop_nib ^ prev_smp[pop_idx]))
                  | (cur_sig[pop_idx] & (pop_nib ^ prev_smp[pop_idx]));
      end
   end
   assign change = pop && slot_valid(pop_slot, e1) && (accepted != cur_sig[pop_idx]);
   assign flag_set = change ? flag_bit(pop_slot, e1) : 16'h0000;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) begin
            cur_sig[i] <= 4'h0;
            dly_sig[i] <= 4'h0;
            prev_smp[i] <= 4'h0;
         end
      end else if (pop) begin
         if (pop_mf) begin
            for (int i = 0; i < 32; i++) begin
               dly_sig[i] <= cur_sig[i];
            end
         end
         // no storage for E1 timeslots zero and sixteen
         if (slot_valid(pop_slot, e1)) begin
            prev_smp[pop_idx] <= pop_nib;
            // current nibble updated with its flag
            cur_sig[pop_idx] <= accepted;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // change flags; a set in the clearing cycle survives
   always_comb begin
      flag_clr = 16'h0000;
      if (reg_rd_i && view && reg_addr_i == signaling_extractor_pkg::ADDR_OFS) begin
         flag_clr[15:8] = 8'hff;
      end
      if (reg_rd_i && view && reg_addr_i == signaling_extractor_pkg::DATA_OFS) begin
         flag_clr[7:0] = 8'hff;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         flags <= 16'h0000;
      end else begin
         // set on change, clear on read
         flags <= (flags & ~flag_clr) | flag_set;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // direct registers
   // launch only above the first segment
   assign launch = reg_wr_i && !view && state == IX_IDLE
                 && reg_addr_i == signaling_extractor_pkg::ADDR_OFS
                 && reg_wdata_i[6:0] >= signaling_extractor_pkg::CUR_BASE;

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         cfg <= signaling_extractor_pkg::CFG_RST;
      end else if (reg_wr_i && reg_addr_i == signaling_extractor_pkg::CFG_OFS) begin
         cfg <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         addr_ctrl <= signaling_extractor_pkg::ADDR_RST;
      end else if (reg_wr_i && !view && state == IX_IDLE && reg_addr_i == signaling_extractor_pkg::ADDR_OFS) begin
         addr_ctrl <= reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         data_buf <= signaling_extractor_pkg::DATA_RST;
      end else if (ix_done && addr_ctrl[signaling_extractor_pkg::RNW_BIT]) begin
         data_buf <= ind_rdata;
      end else if (reg_wr_i && !view && state == IX_IDLE && reg_addr_i == signaling_extractor_pkg::DATA_OFS) begin
         data_buf <= reg_wdata_i;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // indirect access sequencer; busy holds off further accesses
   assign ix_done = (state == IX_BUSY) && (ix_cnt == 2'(signaling_extractor_pkg::INDIRECT_CYCLES - 1));

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= IX_IDLE;
         ix_cnt <= 2'h0;
      end else begin
         unique case (state)
            IX_IDLE: begin
               ix_cnt <= 2'h0;
               if (launch) begin
                  state <= IX_BUSY;
               end
            end
            IX_BUSY: begin
               ix_cnt <= ix_cnt + 2'h1;
               if (ix_done) begin
                  state <= IX_IDLE;
               end
            end
         endcase
      end
   end

   always_comb begin
      logic [6:0] a;
      logic [4:0] k;
      a = addr_ctrl[6:0];
      k = a[4:0];
      ind_rdata = 8'h00;
      if (a >= signaling_extractor_pkg::CUR_BASE && a < signaling_extractor_pkg::DLY_BASE) begin
         // slot n high, n+16 low; E1 zero and sixteen read zero
         ind_rdata[7:4] = (e1 && k[3:0] == 4'h0) ? 4'h0 : cur_sig[{1'b0, k[3:0]}];
         ind_rdata[3:0] = (e1 && k[3:0] == 4'h0) ? 4'h0 : cur_sig[{1'b1, k[3:0]}];
      end else if (a >= signaling_extractor_pkg::DLY_BASE && a < signaling_extractor_pkg::PCFG_BASE) begin
         if (e1 || a <= signaling_extractor_pkg::DLY_T1_TOP) begin
            ind_rdata[3:0] = dly_sig[k];
         end
      end else if (a <= signaling_extractor_pkg::PCFG_TOP) begin
         ind_rdata[3:0] = pcfg[k];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         for (int i = 0; i < 32; i++) begin
            pcfg[i] <= signaling_extractor_pkg::PCFG_RST;
         end
      end else if (ix_done && !addr_ctrl[signaling_extractor_pkg::RNW_BIT]
                   && addr_ctrl[6:0] >= signaling_extractor_pkg::PCFG_BASE
                   && addr_ctrl[6:0] <= signaling_extractor_pkg::PCFG_TOP) begin
         pcfg[addr_ctrl[4:0]] <= data_buf[3:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register read port
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         // view decides what offsets 0x50 to 0x53 return
         unique case (reg_addr_i)
            signaling_extractor_pkg::CFG_OFS: reg_rdata_o <= view ? (cfg & (8'h01 << signaling_extractor_pkg::VIEW_BIT)) : cfg;
            signaling_extractor_pkg::STAT_OFS: reg_rdata_o <= view ? 8'h00 : {state != IX_IDLE, 7'h00};
            signaling_extractor_pkg::ADDR_OFS: reg_rdata_o <= view ? flags[15:8] : addr_ctrl;
            signaling_extractor_pkg::DATA_OFS: reg_rdata_o <= view ? flags[7:0] : data_buf;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // receive pcm conditioning
   logic [3:0] pc;
   logic [7:0] fixed;
   logic [7:0] inv_mask;
   assign pc = per_slot_config_enable ? pcfg[slot_index(pcm_slot_i, e1)] : 4'h0;

   always_comb begin
      fixed = pcm_data_i;
      if (!e1 && pcm_sig_frame_i && pc[signaling_extractor_pkg::PC_INV_LO]) begin
         fixed[0] = pc[signaling_extractor_pkg::PC_FIX_LVL];
      end
      inv_mask = 8'h00;
      if (e1) begin
         unique case (pc[signaling_extractor_pkg::PC_INV_HI:signaling_extractor_pkg::PC_INV_LO])
            2'b01: inv_mask = signaling_extractor_pkg::E1_EVEN_MASK;
            2'b10: inv_mask = signaling_extractor_pkg::E1_ODD_MASK;
            2'b11: inv_mask = 8'hff;
            default: inv_mask = 8'h00;
         endcase
      end else begin
         unique case ({pc[signaling_extractor_pkg::PC_INV_HI], msb_invert_control_i})
            2'b10: inv_mask = 8'hff;
            2'b01: inv_mask = signaling_extractor_pkg::MSB_MASK;
            2'b11: inv_mask = ~signaling_extractor_pkg::MSB_MASK;
            default: inv_mask = 8'h00;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pcm_valid_o <= 1'b0;
         backplane_rx_pcm_out_o <= 8'h00;
      end else begin
         pcm_valid_o <= pcm_valid_i;
         if (milliwatt_i) begin
            backplane_rx_pcm_out_o <= milliwatt_code_i;
         end else if (trunk_cond_i) begin
            backplane_rx_pcm_out_o <= trunk_code_i;
         end else begin
            backplane_rx_pcm_out_o <= fixed ^ inv_mask;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   busy_len_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      launch |=> (state == IX_BUSY) [*2] ##1 (state == IX_IDLE))
      else $error("busy did not last two cycles");
   seg1_idle_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (reg_wr_i && state == IX_IDLE && reg_addr_i == signaling_extractor_pkg::ADDR_OFS
       && reg_wdata_i[6:4] == 3'h0)
      |=> state == IX_IDLE)
      else $error("first segment address launched an access");
   mid_clear_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (flag_clr[15] && flag_set[15:8] == 8'h00) |=> flags[15:8] == 8'h00)
      else $error("upper flag byte not cleared by read");
   low_clear_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (flag_clr[0] && flag_set[7:0] == 8'h00) |=> flags[7:0] == 8'h00)
      else $error("lower flag byte not cleared by read");
   ts17_flag_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (change && e1 && pop_slot == signaling_extractor_pkg::E1_FLAG16_TS) |=> flags[15])
      else $error("timeslot seventeen change lost");
   read_result_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ix_done && addr_ctrl[signaling_extractor_pkg::RNW_BIT]) |=> data_buf == $past(ind_rdata))
      else $error("read result not in data buffer");
   write_cfg_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (ix_done && !addr_ctrl[signaling_extractor_pkg::RNW_BIT] && addr_ctrl[6:0] >= signaling_extractor_pkg::PCFG_BASE
       && addr_ctrl[6:0] <= signaling_extractor_pkg::PCFG_TOP)
      |=> pcfg[$past(addr_ctrl[4:0])] == $past(data_buf[3:0]))
      else $error("buffered byte not written");
   mw_prio_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      milliwatt_i |=> backplane_rx_pcm_out_o == $past(milliwatt_code_i))
      else $error("milliwatt code not inserted");
   fix_level_a: assert property (
      @(posedge core_clk_i) disable iff (rst_i)
      (!e1 && pcm_sig_frame_i && pc[2] && !pc[3] && !msb_invert_control_i
       && !milliwatt_i && !trunk_cond_i)
      |=> backplane_rx_pcm_out_o[0] == $past(pc[1]))
      else $error("signaling bit not fixed");
endmodule // signaling_extract_indirect_regs

`default_nettype wire

// >>> testbench/sig_source.sv
// signaling sample source standing in for the receive framer
`timescale 1ns/10ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
module sig_source (
   input wire logic clk_i,        // core clock
   input wire logic rst_i,        // async reset
   input wire logic req_i,        // load one sample
   input wire logic [4:0] slot_i, // requested slot
   input wire logic [3:0] nib_i,  // requested nibble
   input wire logic mf_i,         // requested multiframe mark
   input wire logic ready_i,      // extractor has room
   output logic valid_o,          // sample offered
   output logic [4:0] slot_o,     // offered slot
   output logic [3:0] nib_o,      // offered nibble
   output logic mf_o,             // offered multiframe mark
   output logic taken_o           // sample accepted at last edge
);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         valid_o <= 1'b0;
         slot_o <= 5'h00;
         nib_o <= 4'h0;
         mf_o <= 1'b0;
         taken_o <= 1'b0;
      end else if (valid_o && ready_i) begin
         // released lines flip so a stale sample can never pass for a fresh one
         valid_o <= 1'b0;
         slot_o <= ~slot_o;
         nib_o <= ~nib_o;
         mf_o <= ~mf_o;
         taken_o <= 1'b1;
      end else begin
         taken_o <= 1'b0;
         if (req_i && !valid_o) begin
            valid_o <= 1'b1;
            slot_o <= slot_i;
            nib_o <= nib_i;
            mf_o <= mf_i;
         end
      end
   end
endmodule // sig_source
`default_nettype wire

// >>> testbench/signaling_extract_indirect_regs_tb_top.sv
// register-level bench for the signaling extractor slice
`timescale 1ns/10ps
`default_nettype none

module signaling_extract_indirect_regs_tb_top;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, e1 = 1'b1, pval = 1'b0;
   logic psig = 1'b0, minv = 1'b0, trk = 1'b0, mw = 1'b0, sreq = 1'b0, smf = 1'b0;
   logic [7:0] addr = 8'h00, wdata = 8'h00, pdata = 8'h00, rdata, pout;
   logic [4:0] pslot = 5'h04, sslot = 5'h00, vslot;
   logic [3:0] snib = 4'h0, vnib;
   logic vmf, svalid, sready, taken, pvo;
   logic [7:0] e1mask [4] = '{8'h00, 8'h55, 8'haa, 8'hff};
   int failures = 0, n_compared = 0;

   always #25 clk = ~clk;

   signaling_extract_indirect_regs #(.FIFO_DEPTH(16)) signaling_extract_indirect_regs_inst (
      .core_clk_i(clk), .rst_i(rst), .reg_addr_i(addr), .reg_wr_i(wr), .reg_rd_i(rd),
      .reg_wdata_i(wdata), .reg_rdata_o(rdata), .e1_not_t1_select_i(e1),
      .sig_valid_i(svalid), .sig_ready_o(sready), .sig_slot_i(vslot), .sig_nibble_i(vnib),
      .sig_mf_start_i(vmf), .pcm_valid_i(pval), .pcm_slot_i(pslot), .pcm_data_i(pdata),
      .pcm_sig_frame_i(psig), .msb_invert_control_i(minv), .trunk_cond_i(trk),
      .trunk_code_i(8'h7e), .milliwatt_i(mw), .milliwatt_code_i(8'h34),
      .pcm_valid_o(pvo), .backplane_rx_pcm_out_o(pout));

   sig_source sig_source_inst (.clk_i(clk), .rst_i(rst), .req_i(sreq), .slot_i(sslot),
      .nib_i(snib), .mf_i(smf), .ready_i(sready), .valid_o(svalid), .slot_o(vslot),
      .nib_o(vnib), .mf_o(vmf), .taken_o(taken));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic finish_test();
      $display("compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic stuck();
      failures++;
      $display("ERROR %0t: wait ran out", $time);
      finish_test();
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rcmp(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask
   task automatic poll();
      for (int i = 0; i < 20; i++) begin
         @(posedge clk);
         addr <= 8'h51;
         rd <= 1'b1;
         @(posedge clk);
         rd <= 1'b0;
         #1 if (rdata[7] === 1'b0) return;
      end
      stuck();
   endtask
   task automatic iwr(input logic [6:0] a, input logic [7:0] v);
      wreg(8'h53, v);
      wreg(8'h52, {1'b0, a});
      poll();
   endtask
   task automatic icmp(input logic [6:0] a, input logic [7:0] e);
      wreg(8'h52, {1'b1, a});
      poll();
      rcmp(8'h53, e);
   endtask
   // t1 channel numbering is unsure between n and n-1, so both slots get it
   task automatic pcfg(input logic [7:0] v);
      iwr(7'h44, v);
      iwr(7'h45, v);
   endtask
   task automatic send(input logic [4:0] s, input logic [3:0] n, input logic m);
      int i;
      @(posedge clk);
      sreq <= 1'b1;
      sslot <= s;
      snib <= n;
      smf <= m;
      @(posedge clk);
      sreq <= 1'b0;
      for (i = 0; i < 20 && taken !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      if (i == 20) stuck();
      // take, drain, update
      repeat (3) @(posedge clk);
   endtask
   // c = {signaling frame, sign invert, trunk, milliwatt}
   task automatic pcm(input logic [7:0] din, input logic [3:0] c, input logic [7:0] e);
      @(posedge clk);
      pval <= 1'b1;
      pdata <= din;
      {psig, minv, trk, mw} <= c;
      @(posedge clk);
      pval <= 1'b0;
      #1 chk({7'h00, pvo}, 8'h01);
      chk(pout, e);
   endtask

   initial begin
      repeat (40000) @(posedge clk);
      stuck();
   end

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rcmp(8'h50, 8'h00);
      rcmp(8'h51, 8'h00);
      rcmp(8'h52, 8'h00);
      rcmp(8'h60, 8'h00);
      chk({7'h00, sready}, 8'h01);
      iwr(7'h45, 8'h0b);
      icmp(7'h45, 8'h0b);
      wreg(8'h53, 8'h5a);
      wreg(8'h52, 8'h85);
      rcmp(8'h51, 8'h00);
      rcmp(8'h53, 8'h5a);
      send(5'd3, 4'ha, 1'b0);
      send(5'd9, 4'h3, 1'b0);
      send(5'd17, 4'hc, 1'b0);
      send(5'd19, 4'h5, 1'b0);
      send(5'd16, 4'hf, 1'b0);
      icmp(7'h13, 8'ha5);
      icmp(7'h10, 8'h00);
      icmp(7'h11, 8'h0c);
      icmp(7'h19, 8'h30);
      wreg(8'h50, 8'h40);
      rcmp(8'h53, 8'h04);
      rcmp(8'h52, 8'h81);
      rcmp(8'h52, 8'h00);
      rcmp(8'h53, 8'h00);
      rcmp(8'h50, 8'h40);
      wreg(8'h50, 8'h00);
      send(5'd5, 4'h6, 1'b1);
      icmp(7'h23, 8'h0a);
      icmp(7'h25, 8'h00);
      send(5'd5, 4'h6, 1'b1);
      icmp(7'h25, 8'h06);
      wreg(8'h50, 8'h01);
      iwr(7'h42, 8'h01);
      send(5'd2, 4'hf, 1'b0);
      icmp(7'h12, 8'h00);
      send(5'd2, 4'hf, 1'b0);
      icmp(7'h12, 8'hf0);
      wreg(8'h50, 8'h41);
      rcmp(8'h53, 8'h12);
      wreg(8'h50, 8'h01);
      for (int c = 0; c < 4; c++) begin
         pcfg({4'h0, c[1:0], 2'b00});
         pcm(8'h3c, 4'h0, 8'h3c ^ e1mask[c]);
      end
      pcm(8'h3c, 4'h2, 8'h7e);
      pcm(8'h3c, 4'h3, 8'h34);
      wreg(8'h50, 8'h00);
      pcm(8'h3c, 4'h0, 8'h3c);
      @(posedge clk);
      e1 <= 1'b0;
      pslot <= 5'h05;
      wreg(8'h50, 8'h01);
      send(5'd1, 4'h9, 1'b0);
      icmp(7'h10, 8'h90);
      icmp(7'h38, 8'h00);
      wreg(8'h50, 8'h41);
      rcmp(8'h53, 8'h01);
      wreg(8'h50, 8'h01);
      pcfg(8'h08);
      pcm(8'h3c, 4'h0, 8'hc3);
      pcm(8'h3c, 4'h4, 8'h43);
      pcfg(8'h00);
      pcm(8'h3c, 4'h4, 8'hbc);
      pcfg(8'h06);
      pcm(8'h3c, 4'h8, 8'h3d);
      pcm(8'h3c, 4'h0, 8'h3c);
      pcfg(8'h0e);
      pcm(8'h3c, 4'h8, 8'hc2);
      pcfg(8'h04);
      pcm(8'h3d, 4'h8, 8'h3c);
      finish_test();
   end
endmodule // signaling_extract_indirect_regs_tb_top
`default_nettype wire
